// file: hdl/pcm_regs.svh
// register offsets, field positions, reset values for the port 6 block
// assumes a 32-bit apb slave with word-aligned registers
`ifndef PCM_REGS_SVH
`define PCM_REGS_SVH
`define PCM_OFF_LATCH     12'h000
`define PCM_OFF_DIR       12'h004
`define PCM_OFF_CTRL      12'h008
`define PCM_OFF_WAITEN    12'h00c
`define PCM_RST_LATCH     8'h80
`define PCM_RST_DIR       8'h80
`define PCM_RST_CTRL      8'h00
`define PCM_RST_WAITEN    8'hff
`define PCM_CTRL_REL_EN   0
`define PCM_CTRL_WMS      1
`define PCM_CTRL_MODE_LSB 4
`define PCM_MODE_SINGLE   3'h7
`endif

// file: hdl/pcm_pkg.sv
// types shared by the port 6 block
// used with pcm_regs.svh
package pcm_pkg;
	typedef struct packed {
		logic low_byte_write_strobe_n;
		logic high_byte_write_strobe_n;
		logic rd_n;
		logic address_strobe_n;
		logic back_n;
	} pcm_bus_ctl_s;
	typedef struct packed {
		logic [6:0] o;
		logic [6:0] oe;
	} pcm_pin_drive_s;
endpackage

// file: hdl/pcm_sync.sv
// three-stage pin synchroniser, a change taken when stages two and three agree
// assumes mclk domain, synchronous active-low reset
`timescale 1ns/1ps
module pcm_sync (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [6:0] pin_in,
	output logic      [6:0] pin_q
);
	logic [6:0] s1_reg;
	logic [6:0] s2_reg;
	logic [6:0] s3_reg;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s1_reg <= 7'h00;
			s2_reg <= 7'h00;
			s3_reg <= 7'h00;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 7; i++) begin : g_agree
			always_ff @(posedge mclk) begin
				if (!rst_n)
					pin_q[i] <= 1'b0;
				else if (s2_reg[i] == s3_reg[i])
					pin_q[i] <= s3_reg[i];
			end
		end
	endgenerate
endmodule

// file: hdl/pcm_port6.sv
// port 6 general i/o with bus control pin sharing, apb register slave
// assumes mclk 20 mhz, synchronous active-low reset, bus strobes from a bus controller
`timescale 1ns/1ps
`include "pcm_regs.svh"
module pcm_port6 (
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	input  wire logic                   hw_standby,
	input  wire logic                   sw_standby,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire pcm_pkg::pcm_bus_ctl_s  bus_ctl,
	input  wire logic [6:0]             pin_i,
	output logic      [6:0]             pin_o,
	output logic      [6:0]             pin_oe,
	output logic                        bus_release_request,
	output logic                        wait_input_n
);
	logic [7:0]             port_output_latch_reg;
	logic [7:0]             port_direction_bits_reg;
	logic [7:0]             bus_release_control_reg;
	logic [7:0]             per_area_wait_enables_reg;
	logic [6:0]             pin_sync;
	logic [2:0]             mode;
	logic                   expanded;
	logic                   gpio2_1;
	logic                   gpio0;
	logic [6:0]             is_gpio;
	logic [7:0]             latch_rd;
	logic [7:0]             rd_sel;
	logic                   wr_en;
	logic                   acc;
	pcm_pkg::pcm_pin_drive_s drive;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	pcm_sync u_sync (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.pin_in (pin_i),
		.pin_q  (pin_sync)
	);

	assign acc      = psel && penable;
	assign wr_en    = acc && pwrite && !sw_standby && !hw_standby;
	assign pready   = 1'b1;
	assign pslverr  = acc && !(hit(paddr, `PCM_OFF_LATCH) || hit(paddr, `PCM_OFF_DIR)
	                  || hit(paddr, `PCM_OFF_CTRL) || hit(paddr, `PCM_OFF_WAITEN));

	// latch register
	always_ff @(posedge mclk) begin
		if (!rst_n || hw_standby)
			port_output_latch_reg <= `PCM_RST_LATCH;
		else if (wr_en && hit(paddr, `PCM_OFF_LATCH))
			port_output_latch_reg <= {1'b1, pwdata[6:0]};
	end

	// direction register
	always_ff @(posedge mclk) begin
		if (!rst_n || hw_standby)
			port_direction_bits_reg <= `PCM_RST_DIR;
		else if (wr_en && hit(paddr, `PCM_OFF_DIR))
			port_direction_bits_reg <= {1'b1, pwdata[6:0]};
	end

	// control registers
	always_ff @(posedge mclk) begin
		if (!rst_n || hw_standby) begin
			bus_release_control_reg   <= `PCM_RST_CTRL;
			per_area_wait_enables_reg <= `PCM_RST_WAITEN;
		end else if (wr_en && hit(paddr, `PCM_OFF_CTRL)) begin
			bus_release_control_reg   <= pwdata[7:0];
		end else if (wr_en && hit(paddr, `PCM_OFF_WAITEN)) begin
			per_area_wait_enables_reg <= pwdata[7:0];
		end
	end

	// pin function selection
	assign mode     = bus_release_control_reg[`PCM_CTRL_MODE_LSB +: 3];
	assign expanded = (mode != `PCM_MODE_SINGLE) && (mode != 3'h0);
	assign gpio2_1  = !expanded || !bus_release_control_reg[`PCM_CTRL_REL_EN];
	assign gpio0    = !expanded || ((&per_area_wait_enables_reg)
	                  && !bus_release_control_reg[`PCM_CTRL_WMS]);
	assign is_gpio  = {{4{!expanded}}, gpio2_1, gpio2_1, gpio0};

	genvar i;
	generate
		for (i = 0; i < 7; i++) begin : g_rd
			assign latch_rd[i] = port_direction_bits_reg[i] ? port_output_latch_reg[i]
			                   : pin_sync[i];
		end
	endgenerate
	assign latch_rd[7] = 1'b1;

	// pin drive, registered
	always_comb begin
		drive.o  = port_output_latch_reg[6:0];
		drive.oe = port_direction_bits_reg[6:0] & is_gpio;
		if (expanded) begin
			drive.o[6:3]  = {bus_ctl.low_byte_write_strobe_n,
			                 bus_ctl.high_byte_write_strobe_n,
			                 bus_ctl.rd_n, bus_ctl.address_strobe_n};
			drive.oe[6:3] = 4'hf;
			if (!gpio2_1) begin
				drive.o[2]  = bus_ctl.back_n;
				drive.oe[2] = 1'b1;
				drive.oe[1] = 1'b0;
			end
			if (!gpio0)
				drive.oe[0] = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pin_o  <= 7'h00;
			pin_oe <= 7'h00;
		end else begin
			pin_o  <= drive.o;
			pin_oe <= drive.oe;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			bus_release_request <= 1'b0;
			wait_input_n        <= 1'b1;
		end else begin
			bus_release_request <= !gpio2_1 && !pin_sync[1];
			wait_input_n        <= gpio0 || pin_sync[0];
		end
	end

	// read select
	always_comb begin
		rd_sel = 8'h00;
		if (hit(paddr, `PCM_OFF_LATCH))
			rd_sel = latch_rd;
		else if (hit(paddr, `PCM_OFF_DIR))
			rd_sel = 8'hff;
		else if (hit(paddr, `PCM_OFF_CTRL))
			rd_sel = bus_release_control_reg;
		else if (hit(paddr, `PCM_OFF_WAITEN))
			rd_sel = per_area_wait_enables_reg;
	end

	// read data taken in the setup cycle, stands through the access phase
	always_ff @(posedge mclk) begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= {24'h00_0000, rd_sel};
		else
			prdata <= 32'h0000_0000;
	end

	latch_bit7_a: assert property (@(posedge mclk) disable iff (!rst_n)
		port_output_latch_reg[7]) else $error("latch bit 7 not one");
	latch_reset_a: assert property (@(posedge mclk)
		!rst_n |=> port_output_latch_reg == 8'h80) else $error("latch reset wrong");
	hw_standby_a: assert property (@(posedge mclk) disable iff (!rst_n)
		hw_standby |=> port_direction_bits_reg == 8'h80) else $error("dir not reset");
	sw_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sw_standby && !hw_standby |=> $stable(port_output_latch_reg))
		else $error("latch changed in sw standby");
	latch_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_en && paddr == `PCM_OFF_LATCH && !hw_standby
		|=> port_output_latch_reg[6:0] == $past(pwdata[6:0])) else $error("write lost");
	strobe_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
		expanded |=> pin_oe[6:3] == 4'hf) else $error("strobes not driven");
	strobe_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
		expanded |=> pin_o[6:3] == $past(bus_ctl[4:1]))
		else $error("strobe levels wrong");
	dir_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		acc && !pwrite && paddr == `PCM_OFF_DIR |-> prdata[7:0] == 8'hff)
		else $error("dir read not ones");
	stored_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		acc && !pwrite && paddr == `PCM_OFF_LATCH && $past(port_direction_bits_reg[0])
		|-> prdata[0] == $past(port_output_latch_reg[0])) else $error("stored read wrong");
	pin_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		acc && !pwrite && paddr == `PCM_OFF_LATCH && !$past(port_direction_bits_reg[1])
		|-> prdata[1] == $past(pin_sync[1])) else $error("pin read wrong");
	read_bit7_a: assert property (@(posedge mclk) disable iff (!rst_n)
		acc && !pwrite && paddr == `PCM_OFF_LATCH |-> prdata[7])
		else $error("latch read bit 7 not one");
	release_pins_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!gpio2_1 |=> pin_oe[2] && !pin_oe[1]) else $error("release pins wrong");
	release_req_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!gpio2_1 |=> bus_release_request == !$past(pin_sync[1]))
		else $error("release request wrong");
	wait_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!gpio0 |=> !pin_oe[0]) else $error("wait pin driven");
	wait_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!gpio0 |=> wait_input_n == $past(pin_sync[0])) else $error("wait input wrong");
	gpio_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!expanded ##1 !expanded |-> pin_oe == $past(port_direction_bits_reg[6:0])
		&& pin_o == $past(port_output_latch_reg[6:0])) else $error("gpio drive wrong");

	release_c: cover property (@(posedge mclk) !gpio2_1 && bus_release_request);
	wait_c: cover property (@(posedge mclk) !gpio0 && !wait_input_n);
	latch_wr_c: cover property (@(posedge mclk) wr_en && paddr == `PCM_OFF_LATCH);
	expanded_c: cover property (@(posedge mclk) expanded && pin_oe == 7'h7c);
	standby_c: cover property (@(posedge mclk) sw_standby && acc && pwrite);
endmodule

// file: sim/pcm_pin_model.sv
// board pins: each pin reads the module level when driven, else the board level
// assumes the bench sets ext_lvl for pins nobody on the chip drives
`timescale 1ns/1ps
module pcm_pin_model (
	input  wire logic [6:0] pin_o,
	input  wire logic [6:0] pin_oe,
	input  wire logic [6:0] ext_lvl,
	output logic      [6:0] pin_i
);
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			pin_i[i] = pin_oe[i] ? pin_o[i] : ext_lvl[i];
		end
	end
endmodule

// file: sim/port6_io_bus_control_mux_tb.sv
// self-checking bench for the port 6 block over apb
// assumes pcm_pin_model on the pins, zero-wait apb slave
`timescale 1ns/1ps
`include "pcm_regs.svh"
module port6_io_bus_control_mux_tb;
	logic                  mclk, rst_n, hw_standby, sw_standby, psel, penable, pwrite;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata;
	logic                  pready, pslverr, brq, wait_n, er;
	pcm_pkg::pcm_bus_ctl_s bus_ctl;
	logic [6:0]            pin_i, pin_o, pin_oe, ext_lvl;
	logic [7:0]            rd;
	int                    fail_count, tests_run, cyc;

	pcm_port6 i_dut (.mclk(mclk), .rst_n(rst_n), .hw_standby(hw_standby),
		.sw_standby(sw_standby), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_ctl(bus_ctl), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe(pin_oe), .bus_release_request(brq), .wait_input_n(wait_n));
	pcm_pin_model i_pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_i(pin_i));

	initial begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end

	task report_and_stop();
		$display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task settle(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task t_reset();
		apb(1, `PCM_OFF_DIR, 8'h7f);
		apb(0, `PCM_OFF_LATCH, 8'h00);
		chk(rd, 8'h80);
		apb(0, `PCM_OFF_DIR, 8'h00);
		chk(rd, 8'hff);
		apb(0, 12'h010, 8'h00);
		chk({7'h00, er}, 8'h01);
		apb(1, 12'h010, 8'h7f);
		apb(0, `PCM_OFF_LATCH, 8'h00);
		chk(rd, 8'h80);
		$display("test reset done");
	endtask

	task t_gpio();
		apb(1, `PCM_OFF_LATCH, 8'h55);
		settle(2);
		chk({1'b0, pin_o}, 8'h55);
		chk({1'b0, pin_oe}, 8'h7f);
		apb(0, `PCM_OFF_LATCH, 8'h00);
		chk(rd, 8'hd5);
		apb(1, `PCM_OFF_DIR, 8'h00);
		ext_lvl <= 7'h2a;
		settle(6);
		chk({1'b0, pin_oe}, 8'h00);
		apb(0, `PCM_OFF_LATCH, 8'h00);
		chk(rd, 8'haa);
		$display("test gpio done");
	endtask

	task t_standby();
		apb(1, `PCM_OFF_DIR, 8'h7f);
		sw_standby <= 1;
		apb(1, `PCM_OFF_LATCH, 8'h00);
		apb(1, `PCM_OFF_DIR, 8'h00);
		sw_standby <= 0;
		apb(0, `PCM_OFF_LATCH, 8'h00);
		chk(rd, 8'hd5);
		hw_standby <= 1;
		settle(2);
		hw_standby <= 0;
		settle(2);
		chk({1'b0, pin_oe}, 8'h00);
		apb(1, `PCM_OFF_DIR, 8'h7f);
		apb(0, `PCM_OFF_LATCH, 8'h00);
		chk(rd, 8'h80);
		$display("test standby done");
	endtask

	task t_expanded();
		ext_lvl <= 7'h00;
		bus_ctl <= 5'b10110;
		apb(1, `PCM_OFF_DIR, 8'h07);
		apb(1, `PCM_OFF_LATCH, 8'h05);
		apb(1, `PCM_OFF_CTRL, 8'h10);
		settle(2);
		chk({1'b0, pin_oe}, 8'h7f);
		chk({1'b0, pin_o}, 8'h5d);
		chk({7'h00, wait_n}, 8'h01);
		apb(1, `PCM_OFF_DIR, 8'h00);
		apb(1, `PCM_OFF_CTRL, 8'h13);
		settle(6);
		chk({1'b0, pin_oe}, 8'h7c);
		chk({3'h0, pin_o[6:2]}, 8'h16);
		chk({7'h00, brq}, 8'h01);
		chk({7'h00, wait_n}, 8'h00);
		ext_lvl <= 7'h03;
		settle(6);
		chk({7'h00, wait_n}, 8'h01);
		chk({7'h00, brq}, 8'h00);
		ext_lvl <= 7'h00;
		apb(1, `PCM_OFF_WAITEN, 8'h7f);
		apb(1, `PCM_OFF_CTRL, 8'h10);
		settle(6);
		chk({7'h00, wait_n}, 8'h00);
		chk({7'h00, brq}, 8'h00);
		apb(1, `PCM_OFF_CTRL, 8'h70);
		apb(1, `PCM_OFF_DIR, 8'h7f);
		settle(2);
		chk({1'b0, pin_oe}, 8'h7f);
		chk({1'b0, pin_o}, 8'h05);
		chk({7'h00, wait_n}, 8'h01);
		$display("test expanded done");
	endtask

	initial begin
		{hw_standby, sw_standby, psel, penable, pwrite} = 5'h00;
		rst_n = 0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		bus_ctl = 5'h1f;
		ext_lvl = 7'h00;
		fail_count = 0;
		tests_run = 0;
		cyc = 0;
		repeat (5) @(posedge mclk);
		rst_n <= 1;
		t_reset();
		t_gpio();
		t_standby();
		t_expanded();
		report_and_stop();
	end
endmodule
